/* smc_pkg.sv */
// smc_pkg: register map, field layout and mode codes of the supply monitor control bank
// assumes one system clock; fuse values arrive as static levels from the fuse loader
package smc_pkg;
   localparam logic [3:0] SMC_ADR_MODE = 4'h0;
   localparam logic [3:0] SMC_ADR_LEVEL = 4'h1;
   localparam logic [3:0] SMC_ADR_WLVL = 4'h8;
   localparam logic [3:0] SMC_ADR_WIRQ = 4'h9;
   localparam logic [3:0] SMC_ADR_WFLAG = 4'hA;
   localparam logic [3:0] SMC_ADR_WSTAT = 4'hB;
   localparam logic [3:0] SMC_ADR_UNLOCK = 4'hF;
   localparam logic [7:0] SMC_IO_UNLOCK_KEY = 8'hD8;
   localparam logic [2:0] SMC_UNLOCK_WINDOW = 3'h4;
   localparam logic [1:0] SMC_MODE_OFF = 2'h0;
   localparam logic [1:0] SMC_MODE_ON = 2'h1;
   localparam logic [1:0] SMC_MODE_SAMPLED = 2'h2;
   localparam logic [1:0] SMC_MODE_STALL = 2'h3;
   localparam logic [1:0] SMC_DIR_FALL = 2'h0;
   localparam logic [1:0] SMC_DIR_RISE = 2'h1;
   localparam logic [1:0] SMC_DIR_BOTH = 2'h2;
   localparam int SMC_CLK_HZ = 125000000;
   localparam int SMC_FAST_HZ = 1000;
   localparam int SMC_SLOW_HZ = 125;
   localparam int SMC_FAST_CYC = SMC_CLK_HZ / SMC_FAST_HZ;
   localparam int SMC_SLOW_CYC = SMC_CLK_HZ / SMC_SLOW_HZ;
   typedef struct packed {
      logic sample_rate_select;
      logic [1:0] active_mode;
      logic [1:0] sleep_mode;
      logic [2:0] threshold_select;
   } smc_fuse_s;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } smc_bus_s;
endpackage

/* smc_regs.sv */
// smc_regs: control registers of the supply drop monitor and its early warning monitor
// assumes a one-cycle register strobe port on clk_sys; comparator output is asynchronous
// How it works
// - protected writes always accepted but only stored inside the unlock window.
// - unlock protection guards the sleep-state mode field only.
// - read-only sample rate bit 4 from fuse; 0 is 1 kHz, 1 is 125 Hz.
// - active mode codes: off, on, sampled, on with wake stalled until ready.
// - active mode in bits 3:2, read-only, fuse-loaded.
// - sleep mode bits 1:0 writable, fuse-loaded; code 3 reserved.
// - threshold select bits 2:0 of level register, read-only from fuse.
// - two-bit warning offset select: 5, 15 or 25 percent above threshold.
// - direction bits 2:1: falling, rising or both crossings.
// - bit 0 of interrupt control enables the warning interrupt.
// - flag sets on a matching crossing, only while the monitor is enabled.
// - live status bit is 1 while supply is below warning threshold.
// - interrupt request stands while flag and enable are both set.
// - warning disabled when monitor off; sampled when monitor is sampled.
// - direction code both sets the flag on interrupt enable while the monitor is on.
// - sleep uses sleep-state mode, wake returns to active-state mode.
//
// Our own choice: the plain strobed port.
module smc_regs
(
   input wire logic clk_sys,
   input wire logic nrst,
   input wire smc_pkg::smc_fuse_s fuse_in,
   input wire smc_pkg::smc_bus_s bus_in,
   output logic [7:0] rd_data_ff,
   input wire logic deep_sleep,
   input wire logic below_warning_async,
   output logic monitor_enable,
   output logic monitor_sample_en,
   output logic monitor_stall_wake,
   output logic [2:0] threshold_out,
   output logic [1:0] warning_offset_out,
   output logic irq
);
   import smc_pkg::*;

   logic fuse_load_ff;
   logic sample_rate_ff;
   logic [1:0] active_mode_ff;
   logic [1:0] sleep_mode_ff;
   logic [2:0] threshold_ff;
   logic [1:0] warn_lvl_ff;
   logic [1:0] warn_dir_ff;
   logic warn_ie_ff;
   logic warn_flag_ff;
   logic warn_stat_ff;
   logic below_s1_ff;
   logic below_s2_ff;
   logic [2:0] unlock_cnt_ff;
   // 20 bits: the 125 Hz period needs 1000000 counts, beyond a 17-bit range
   logic [19:0] rate_cnt_ff;
   logic sample_tick;
   logic [1:0] eff_mode;
   logic mon_on;
   logic sample_now;
   logic rise;
   logic fall;
   logic hit;
   logic flag_clr;
   logic unlocked;
   logic [7:0] nxt_rd;

   function automatic logic is_wr(input smc_bus_s b, input logic [3:0] a);
      return b.wr && (b.addr == a);
   endfunction

   // fuses copied on the first edge after reset release, not under reset
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         fuse_load_ff <= 1'b1;
      end else begin
         fuse_load_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sample_rate_ff <= 1'b0;
         active_mode_ff <= SMC_MODE_OFF;
         threshold_ff <= 3'h0;
      end else if (fuse_load_ff) begin
         sample_rate_ff <= fuse_in.sample_rate_select;
         active_mode_ff <= fuse_in.active_mode;
         threshold_ff <= fuse_in.threshold_select;
      end
   end

   // unlock window counts bus reads and writes as instructions
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         unlock_cnt_ff <= 3'h0;
      end else if (is_wr(bus_in, SMC_ADR_UNLOCK) && bus_in.wdata == SMC_IO_UNLOCK_KEY) begin
         unlock_cnt_ff <= SMC_UNLOCK_WINDOW;
      end else if (unlock_cnt_ff != 3'h0 && (bus_in.wr || bus_in.rd)) begin
         unlock_cnt_ff <= unlock_cnt_ff - 3'h1;
      end
   end
   assign unlocked = (unlock_cnt_ff != 3'h0);

   // protected sleep field; reserved code 3 kept out
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sleep_mode_ff <= SMC_MODE_OFF;
      end else if (fuse_load_ff) begin
         sleep_mode_ff <= fuse_in.sleep_mode;
      end else if (is_wr(bus_in, SMC_ADR_MODE) && unlocked
                   && bus_in.wdata[1:0] != SMC_MODE_STALL) begin
         sleep_mode_ff <= bus_in.wdata[1:0];
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         warn_lvl_ff <= 2'h0;
         warn_dir_ff <= SMC_DIR_FALL;
         warn_ie_ff <= 1'b0;
      end else begin
         if (is_wr(bus_in, SMC_ADR_WLVL)) begin
            warn_lvl_ff <= bus_in.wdata[1:0];
         end
         if (is_wr(bus_in, SMC_ADR_WIRQ)) begin
            warn_dir_ff <= bus_in.wdata[2:1];
            warn_ie_ff <= bus_in.wdata[0];
         end
      end
   end

   assign eff_mode = deep_sleep ? sleep_mode_ff : active_mode_ff;
   assign mon_on = (eff_mode != SMC_MODE_OFF);

   // sample-rate divider; restarts each wrap
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rate_cnt_ff <= 20'h0;
      end else if (sample_tick) begin
         rate_cnt_ff <= 20'h0;
      end else begin
         rate_cnt_ff <= rate_cnt_ff + 20'h1;
      end
   end
   // divider runs free, so a mode switch waits at most one period for its first sample
   assign sample_tick = sample_rate_ff ? (rate_cnt_ff == 20'(SMC_SLOW_CYC - 1))
                                       : (rate_cnt_ff == 20'(SMC_FAST_CYC - 1));
   assign sample_now = mon_on && ((eff_mode != SMC_MODE_SAMPLED) || sample_tick);

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         below_s1_ff <= 1'b0;
         below_s2_ff <= 1'b0;
      end else begin
         below_s1_ff <= below_warning_async;
         below_s2_ff <= below_s1_ff;
      end
   end

   // live status, refreshed only when sampled
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         warn_stat_ff <= 1'b0;
      end else if (sample_now) begin
         warn_stat_ff <= below_s2_ff;
      end
   end

   // supply falling means status going 0 to 1
   assign fall = sample_now && below_s2_ff && !warn_stat_ff;
   assign rise = sample_now && !below_s2_ff && warn_stat_ff;
   always_comb begin
      unique case (warn_dir_ff)
         SMC_DIR_FALL: hit = fall;
         SMC_DIR_RISE: hit = rise;
         SMC_DIR_BOTH: hit = fall || rise;
         default: hit = 1'b0;
      endcase
   end

   // enabling with both directions forces the flag
   logic ie_set;
   assign ie_set = is_wr(bus_in, SMC_ADR_WIRQ) && bus_in.wdata[0] && !warn_ie_ff
                   && bus_in.wdata[2:1] == SMC_DIR_BOTH && mon_on;
   assign flag_clr = is_wr(bus_in, SMC_ADR_WFLAG) && bus_in.wdata[0];

   // flag sets only with monitor on, clears at any time; set beats clear
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         warn_flag_ff <= 1'b0;
      end else if ((mon_on && hit) || ie_set) begin
         warn_flag_ff <= 1'b1;
      end else if (flag_clr) begin
         warn_flag_ff <= 1'b0;
      end
   end

   // level request while flag and enable
   assign irq = warn_flag_ff && warn_ie_ff;

   // effective mode codes map to monitor controls; stall wake from the active code
   assign monitor_enable = mon_on;
   assign monitor_sample_en = (eff_mode == SMC_MODE_SAMPLED);
   assign monitor_stall_wake = !deep_sleep && (active_mode_ff == SMC_MODE_STALL);
   assign threshold_out = threshold_ff;
   assign warning_offset_out = warn_lvl_ff;

   // unused offsets and bits read zero
   always_comb begin
      nxt_rd = 8'h00;
      unique case (bus_in.addr)
         SMC_ADR_MODE: nxt_rd = {3'h0, sample_rate_ff, active_mode_ff, sleep_mode_ff};
         SMC_ADR_LEVEL: nxt_rd = {5'h00, threshold_ff};
         SMC_ADR_WLVL: nxt_rd = {6'h00, warn_lvl_ff};
         SMC_ADR_WIRQ: nxt_rd = {5'h00, warn_dir_ff, warn_ie_ff};
         SMC_ADR_WFLAG: nxt_rd = {7'h00, warn_flag_ff};
         SMC_ADR_WSTAT: nxt_rd = {7'h00, warn_stat_ff};
         default: nxt_rd = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rd_data_ff <= 8'h00;
      end else if (bus_in.rd) begin
         rd_data_ff <= nxt_rd;
      end else begin
         rd_data_ff <= 8'h00;
      end
   end

   chk_locked_write_held: assert property (@(posedge clk_sys) disable iff (!nrst)
      is_wr(bus_in, SMC_ADR_MODE) && !unlocked && !fuse_load_ff |=> $stable(sleep_mode_ff))
      else $error("sleep mode changed without unlock");
   chk_irq_level: assert property (@(posedge clk_sys) disable iff (!nrst)
      irq == (warn_flag_ff && warn_ie_ff)) else $error("irq mismatch");
   chk_flag_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
      flag_clr && !hit && !ie_set |=> !warn_flag_ff) else $error("flag not cleared");
   chk_flag_off_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
      !mon_on && !flag_clr |=> $stable(warn_flag_ff)) else $error("flag moved while off");
   chk_active_ro: assert property (@(posedge clk_sys) disable iff (!nrst)
      !fuse_load_ff |=> $stable(active_mode_ff)) else $error("active mode changed");
   chk_sleep_legal: assert property (@(posedge clk_sys) disable iff (!nrst)
      is_wr(bus_in, SMC_ADR_MODE) && unlocked && bus_in.wdata[1:0] != SMC_MODE_STALL
      && !fuse_load_ff |=> sleep_mode_ff == $past(bus_in.wdata[1:0]))
      else $error("unlocked write lost");
   chk_read_reserved: assert property (@(posedge clk_sys) disable iff (!nrst)
      bus_in.rd && bus_in.addr inside {[4'h2:4'h7]} |=> rd_data_ff == 8'h00)
      else $error("reserved read nonzero");
   chk_status_track: assert property (@(posedge clk_sys) disable iff (!nrst)
      sample_now |=> warn_stat_ff == $past(below_s2_ff)) else $error("status stale");

   // unlock procedure in two steps: key write, then the protected write
   sequence seq_key_write;
      is_wr(bus_in, SMC_ADR_UNLOCK) && bus_in.wdata == SMC_IO_UNLOCK_KEY;
   endsequence
   sequence seq_legal_sleep_write;
      is_wr(bus_in, SMC_ADR_MODE) && bus_in.wdata[1:0] != SMC_MODE_STALL && !fuse_load_ff;
   endsequence

   chk_window_load: assert property (@(posedge clk_sys) disable iff (!nrst)
      seq_key_write |=> unlock_cnt_ff == SMC_UNLOCK_WINDOW)
      else $error("unlock window not loaded");
   chk_unlock_store: assert property (@(posedge clk_sys) disable iff (!nrst)
      seq_key_write ##1 seq_legal_sleep_write |=> sleep_mode_ff == $past(bus_in.wdata[1:0]))
      else $error("unlocked sleep write lost");
   chk_window_spent: assert property (@(posedge clk_sys) disable iff (!nrst)
      unlock_cnt_ff == 3'h1 && (bus_in.wr || bus_in.rd)
      && !(is_wr(bus_in, SMC_ADR_UNLOCK) && bus_in.wdata == SMC_IO_UNLOCK_KEY)
      |=> !unlocked) else $error("unlock window too long");
   chk_ie_both_set: assert property (@(posedge clk_sys) disable iff (!nrst)
      is_wr(bus_in, SMC_ADR_WIRQ) && bus_in.wdata[0] && !warn_ie_ff
      && bus_in.wdata[2:1] == SMC_DIR_BOTH && mon_on |=> warn_flag_ff)
      else $error("flag not forced on enable");
   chk_set_beats_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
      flag_clr && hit |=> warn_flag_ff) else $error("clear beat a crossing");
   chk_irq_held: assert property (@(posedge clk_sys) disable iff (!nrst)
      irq && !flag_clr && !is_wr(bus_in, SMC_ADR_WIRQ) |=> irq)
      else $error("irq dropped without clear");
   // read data zero outside the answer cycle
   chk_read_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
      !bus_in.rd |=> rd_data_ff == 8'h00) else $error("read data outside answer");
   chk_tick_restart: assert property (@(posedge clk_sys) disable iff (!nrst)
      sample_tick |=> rate_cnt_ff == 20'h0) else $error("divider did not restart");
   // sampled mode holds status between ticks
   chk_sampled_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
      eff_mode == SMC_MODE_SAMPLED && !sample_tick |=> $stable(warn_stat_ff))
      else $error("status moved between samples");
   chk_status_off: assert property (@(posedge clk_sys) disable iff (!nrst)
      !sample_now |=> $stable(warn_stat_ff)) else $error("status moved unsampled");
   chk_fuse_copy: assert property (@(posedge clk_sys) disable iff (!nrst)
      fuse_load_ff |=> threshold_ff == $past(fuse_in.threshold_select))
      else $error("threshold fuse not copied");
   chk_level_ro: assert property (@(posedge clk_sys) disable iff (!nrst)
      !fuse_load_ff |=> $stable(threshold_ff)) else $error("threshold changed");
   chk_rate_ro: assert property (@(posedge clk_sys) disable iff (!nrst)
      !fuse_load_ff |=> $stable(sample_rate_ff)) else $error("sample rate changed");
   chk_lvl_write: assert property (@(posedge clk_sys) disable iff (!nrst)
      is_wr(bus_in, SMC_ADR_WLVL) |=> warn_lvl_ff == $past(bus_in.wdata[1:0]))
      else $error("offset write lost");
   chk_dir_write: assert property (@(posedge clk_sys) disable iff (!nrst)
      is_wr(bus_in, SMC_ADR_WIRQ) |=> warn_dir_ff == $past(bus_in.wdata[2:1]))
      else $error("direction write lost");
   // sleep mode off stops the monitor
   chk_sleep_off: assert property (@(posedge clk_sys) disable iff (!nrst)
      deep_sleep && sleep_mode_ff == SMC_MODE_OFF |-> !monitor_enable)
      else $error("monitor on in sleep off");
   chk_stall_awake: assert property (@(posedge clk_sys) disable iff (!nrst)
      deep_sleep |-> !monitor_stall_wake) else $error("stall asserted in sleep");
   chk_ie_write: assert property (@(posedge clk_sys) disable iff (!nrst)
      is_wr(bus_in, SMC_ADR_WIRQ) |=> warn_ie_ff == $past(bus_in.wdata[0]))
      else $error("enable write lost");
endmodule

/* supply_monitor_control_regs_tb.sv */
// supply_monitor_control_regs_tb: self-checking bench for the supply monitor register bank
// assumes smc_pkg and smc_regs compiled first; bench drives every input port of the bank itself
module supply_monitor_control_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import smc_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   smc_fuse_s fuse_in = '0;
   smc_bus_s bus_in = '0;
   logic deep_sleep = 1'b0;
   logic below_warning_async = 1'b0;
   logic [7:0] rd_data_ff;
   logic monitor_enable;
   logic irq;
   logic [1:0] warning_offset_out;
   logic [7:0] exp_q[$];
   logic rd_pend = 1'b0;
   int err_count = 0;
   int n_checks = 0;
   logic [7:0] fz;
   logic [7:0] e0;
   logic [1:0] slp;

   always #4 clk_sys = ~clk_sys;

   smc_regs uut (.clk_sys(clk_sys), .nrst(nrst), .fuse_in(fuse_in), .bus_in(bus_in),
      .rd_data_ff(rd_data_ff), .deep_sleep(deep_sleep),
      .below_warning_async(below_warning_async), .monitor_enable(monitor_enable),
      .monitor_sample_en(), .monitor_stall_wake(), .threshold_out(),
      .warning_offset_out(warning_offset_out), .irq(irq));

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic fail(input string m);
      err_count++;
      $display("ERROR %0t %s", $time, m);
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) fail($sformatf("value %h expected %h", got, exp));
   endtask
   task automatic chk1(input logic got, input logic exp, input string what);
      n_checks++;
      if (got !== exp) fail($sformatf("%s is %b expected %b", what, got, exp));
   endtask

   // read data stands only in the cycle after the strobe
   always @(posedge clk_sys) rd_pend <= bus_in.rd;
   always @(negedge clk_sys) begin
      if (rd_pend) begin
         if (exp_q.size() == 0) fail("read data without a pending note");
         else chk8(rd_data_ff, exp_q.pop_front());
      end
   end

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_in <= '{a, d, 1'b1, 1'b0};
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      bus_in <= '{a, 8'h00, 1'b0, 1'b1};
      exp_q.push_back(e);
   endtask
   task automatic idle(input int n);
      @(posedge clk_sys);
      bus_in <= '0;
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wirq(input logic v);
      int i;
      for (i = 0; i < 20 && irq !== v; i++) @(negedge clk_sys);
      chk1(irq, v, "irq");
      if (i == 20) print_verdict();
   endtask

   initial begin
      void'($urandom(43));
      fz = 8'($urandom);
      slp = (fz[1:0] == 2'h3) ? 2'h2 : fz[1:0];
      fuse_in <= '{fz[7], SMC_MODE_ON, slp, fz[4:2]};
      e0 = {3'h0, fz[7], SMC_MODE_ON, slp};
      repeat (6) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rd(SMC_ADR_MODE, e0);
      rd(SMC_ADR_LEVEL, {5'h0, fz[4:2]});
      for (int a = 2; a < 15; a++) rd(4'(a), 8'h00);
      wr(SMC_ADR_MODE, 8'hFF);
      wr(SMC_ADR_LEVEL, 8'hFF);
      wr(4'h3, 8'hFF);
      rd(SMC_ADR_MODE, e0);
      rd(SMC_ADR_LEVEL, {5'h0, fz[4:2]});
      rd(4'h3, 8'h00);
      $display("test reset and read-only done");
      wr(SMC_ADR_UNLOCK, SMC_IO_UNLOCK_KEY);
      wr(SMC_ADR_MODE, 8'h02);
      e0[1:0] = 2'h2;
      rd(SMC_ADR_MODE, e0);
      wr(SMC_ADR_UNLOCK, SMC_IO_UNLOCK_KEY);
      wr(SMC_ADR_MODE, 8'h03);
      rd(SMC_ADR_MODE, e0);
      wr(SMC_ADR_UNLOCK, SMC_IO_UNLOCK_KEY);
      repeat (4) rd(SMC_ADR_WLVL, 8'h00);
      wr(SMC_ADR_MODE, 8'h01);
      rd(SMC_ADR_MODE, e0);
      $display("test timed unlock done");
      wr(SMC_ADR_WLVL, 8'hFF);
      wr(SMC_ADR_WIRQ, 8'hFE);
      rd(SMC_ADR_WLVL, 8'h03);
      rd(SMC_ADR_WIRQ, 8'h06);
      idle(1);
      chk8({6'h0, warning_offset_out}, 8'h03);
      wr(SMC_ADR_WIRQ, 8'h01);
      idle(1);
      below_warning_async <= 1'b1;
      wirq(1'b1);
      rd(SMC_ADR_WFLAG, 8'h01);
      rd(SMC_ADR_WSTAT, 8'h01);
      wr(SMC_ADR_WIRQ, 8'h00);
      idle(1);
      wirq(1'b0);
      wr(SMC_ADR_WFLAG, 8'h00);
      rd(SMC_ADR_WFLAG, 8'h01);
      wr(SMC_ADR_WFLAG, 8'h01);
      rd(SMC_ADR_WFLAG, 8'h00);
      wr(SMC_ADR_WIRQ, 8'h03);
      idle(1);
      below_warning_async <= 1'b0;
      wirq(1'b1);
      wr(SMC_ADR_WFLAG, 8'h01);
      idle(1);
      wirq(1'b0);
      wr(SMC_ADR_WIRQ, 8'h00);
      wr(SMC_ADR_WIRQ, 8'h05);
      idle(1);
      rd(SMC_ADR_WFLAG, 8'h01);
      idle(1);
      wirq(1'b1);
      wr(SMC_ADR_WFLAG, 8'h01);
      wr(SMC_ADR_WIRQ, 8'h00);
      $display("test warning flag done");
      wr(SMC_ADR_UNLOCK, SMC_IO_UNLOCK_KEY);
      wr(SMC_ADR_MODE, 8'h00);
      e0[1:0] = 2'h0;
      rd(SMC_ADR_MODE, e0);
      idle(1);
      deep_sleep <= 1'b1;
      @(negedge clk_sys);
      chk1(monitor_enable, 1'b0, "sleep enable");
      wr(SMC_ADR_WIRQ, 8'h05);
      idle(1);
      below_warning_async <= 1'b1;
      idle(8);
      rd(SMC_ADR_WFLAG, 8'h00);
      idle(1);
      chk1(irq, 1'b0, "irq in sleep");
      deep_sleep <= 1'b0;
      @(negedge clk_sys);
      chk1(monitor_enable, 1'b1, "wake enable");
      $display("test sleep mode done");
      print_verdict();
   end
endmodule
